/* inc/nps_pkg.sv */
/*
 * nps_pkg: constants and carrier types of the shared-bus flash / pseudo static ram host.
 * Assumes a 20 MHz system clock; times are in ns and turned into cycle counts here.
 */
package nps_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 50;
    // access pulse, bus turnaround and deep power-down exit hold, as least times
    localparam int ACCESS_TIME_NS = 70;
    localparam int TURNAROUND_TIME_NS = 20;
    localparam int POWER_DOWN_EXIT_HOLD_TIME_NS = 150000;
    localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC_RAW = (TURNAROUND_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TURN_CYC = (TURN_CYC_RAW < 1) ? 1 : TURN_CYC_RAW;
    localparam int EXIT_HOLD_CYC =
        (POWER_DOWN_EXIT_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // pin inputs pass two flops; a flash read strobe must outlast them to see wait
    localparam int SYNC_CYC = 2;
    localparam int RD_STROBE_CYC = (ACCESS_CYC > SYNC_CYC) ? ACCESS_CYC : SYNC_CYC + 1;
    localparam int CNT_W = 16;
    localparam logic [3:0] SEL_PRST = 4'h0;

    typedef enum logic [2:0] {
        NPS_OP_FLASH_RD = 3'b000,
        NPS_OP_FLASH_WR = 3'b001,
        NPS_OP_RAM_RD = 3'b010,
        NPS_OP_RAM_WR = 3'b011,
        NPS_OP_RAM_WAKE = 3'b100,
        NPS_OP_FLASH_RST = 3'b101
    } nps_op_t;

    typedef struct packed {
        nps_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic upper_en;
        logic lower_en;
    } nps_req_t;

    // pin-side control, all active low except clk
    typedef struct packed {
        logic flash_reset_n;
        logic flash_ce_n;
        logic flash_oe_n;
        logic flash_we_n;
        logic address_valid_latch_n;
        logic clk;
        logic ram_ce_n;
        logic ram_oe_n;
        logic ram_we_n;
        logic upper_byte_enable_n;
        logic lower_byte_enable_n;
    } nps_ctl_t;

    localparam nps_ctl_t CTL_IDLE = '{flash_reset_n: 1'b1, flash_ce_n: 1'b1,
        flash_oe_n: 1'b1, flash_we_n: 1'b1, address_valid_latch_n: 1'b1, clk: 1'b0,
        ram_ce_n: 1'b1, ram_oe_n: 1'b1, ram_we_n: 1'b1, upper_byte_enable_n: 1'b1,
        lower_byte_enable_n: 1'b1};
endpackage : nps_pkg

/* core/nps_sync.sv */
/*
 * nps_sync: two-flop synchroniser for a bus of pin inputs.
 * Assumes inputs are asynchronous to SYS_CLK; only the second stage is read outside.
 */
`timescale 1ns/1ns
`default_nettype none
module nps_sync #(
    parameter int W = 17
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : nps_sync
`default_nettype wire

/* core/nps_host.sv */
/*
 * nps_host: asynchronous host controller for a shared-bus flash and pseudo static ram pair.
 * Assumes one request at a time on REQ/REQ_READY, pins wired to the package directly,
 * and a board pull that resolves the data bus when no one drives it.
 */
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - upper byte lines carry ram data only while upper enable low.
// - lower byte lines carry ram data only while lower enable low.
// - flash read: reset high, ce/oe low, we/latch high, clk low, ram ce high.
// - ram access: flash ce high, ram ce low, oe or we low, bytes low.
// - clock line held low during ram asynchronous operation.
// - deep power-down exit needs ce held low for the exit hold time.
// - never two dies driving the data bus at once.
module nps_host
    import nps_pkg::*;
#(
    parameter int EXIT_HOLD = EXIT_HOLD_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire nps_pkg::nps_req_t REQ,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic WAIT_ACTIVE_HIGH,
    output logic [nps_pkg::DATA_W-1:0] RDATA,
    output logic RDATA_VALID,
    output logic FLASH_BUSY,
    output logic [nps_pkg::ADDR_W-1:0] ADDR,
    output logic [nps_pkg::DATA_W-1:0] DQ_OUT,
    output logic [nps_pkg::DATA_W-1:0] DQ_OE,
    input wire logic [nps_pkg::DATA_W-1:0] DQ_IN,
    input wire logic WAIT_IN,
    output nps_pkg::nps_ctl_t CTL
);
    import nps_pkg::*;

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NPS_IDLE = 3'b000,
        NPS_SETUP = 3'b001,
        NPS_STROBE = 3'b010,
        NPS_RELEASE = 3'b011,
        NPS_TURN = 3'b100
    } nps_state_t;

    nps_state_t state_r, state_nxt;
    nps_req_t req_r;
    logic [CNT_W-1:0] cnt_r;
    logic [DATA_W:0] pin_sync;
    logic wait_asserted;

    nps_sync #(.W(DATA_W + 1)) u_sync (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .d({WAIT_IN, DQ_IN}),
        .q(pin_sync)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic is_ram(input nps_op_t op);
        return op == NPS_OP_RAM_RD || op == NPS_OP_RAM_WR || op == NPS_OP_RAM_WAKE;
    endfunction

    function automatic logic is_write(input nps_op_t op);
        return op == NPS_OP_FLASH_WR || op == NPS_OP_RAM_WR;
    endfunction

    // polarity is programmed in the flash; software tells us which it chose
    assign wait_asserted = pin_sync[DATA_W] ~^ WAIT_ACTIVE_HIGH;

    wire cnt_done = (cnt_r == '0);
    wire strobe_hold = (req_r.op == NPS_OP_RAM_WAKE) ? 1'b0 : wait_asserted
        && req_r.op == NPS_OP_FLASH_RD;
    // flash reads run long enough for the synchronised wait to be seen at the end
    wire [CNT_W-1:0] strobe_len = (req_r.op == NPS_OP_RAM_WAKE) ? CNT_W'(EXIT_HOLD - 1)
        : (req_r.op == NPS_OP_FLASH_RD) ? CNT_W'(RD_STROBE_CYC - 1)
        : CNT_W'(ACCESS_CYC - 1);
    wire take = (state_r == NPS_IDLE) && REQ_VALID;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            NPS_IDLE: begin
                if (REQ_VALID) begin
                    state_nxt = NPS_SETUP;
                end
            end
            NPS_SETUP: begin
                state_nxt = NPS_STROBE;
            end
            NPS_STROBE: begin
                if (cnt_done && !strobe_hold) begin
                    state_nxt = NPS_RELEASE;
                end
            end
            NPS_RELEASE: begin
                state_nxt = NPS_TURN;
            end
            NPS_TURN: begin
                if (cnt_done) begin
                    state_nxt = NPS_IDLE;
                end
            end
            default: begin
                state_nxt = NPS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    nps_ctl_t ctl_nxt;
    nps_req_t req_use;
    // on the take edge req_r is still stale; setup pins must follow the new request
    assign req_use = take ? REQ : req_r;
    wire in_access = (state_nxt == NPS_SETUP || state_nxt == NPS_STROBE);
    wire strobing = (state_nxt == NPS_STROBE);
    wire ram_sel = is_ram(req_use.op);
    wire op_wr = is_write(req_use.op);

    always_comb begin
        ctl_nxt = CTL_IDLE;
        ctl_nxt.clk = 1'b0;
        ctl_nxt.flash_reset_n = !(in_access && req_use.op == NPS_OP_FLASH_RST);
        if (in_access && req_use.op != NPS_OP_FLASH_RST) begin
            // only one die enable at a time; idle between keeps both high
            ctl_nxt.flash_ce_n = ram_sel;
            ctl_nxt.ram_ce_n = !ram_sel;
            if (ram_sel && req_use.op != NPS_OP_RAM_WAKE) begin
                ctl_nxt.upper_byte_enable_n = !req_use.upper_en;
                ctl_nxt.lower_byte_enable_n = !req_use.lower_en;
                ctl_nxt.ram_oe_n = !(strobing && !op_wr);
                ctl_nxt.ram_we_n = !(strobing && op_wr);
            end else if (!ram_sel) begin
                ctl_nxt.flash_oe_n = !(strobing && !op_wr);
                ctl_nxt.flash_we_n = !(strobing && op_wr);
            end
        end
    end

    // host drives only on writes while a chip is selected, never while anyone reads
    wire drive_nxt = in_access && op_wr;
    wire [DATA_W-1:0] byte_oe = ram_sel ? {{8{req_use.upper_en}}, {8{req_use.lower_en}}}
        : {DATA_W{1'b1}};

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= NPS_IDLE;
            cnt_r <= '0;
            req_r <= '0;
            CTL <= CTL_IDLE;
            DQ_OE <= '0;
            DQ_OUT <= '0;
            ADDR <= '0;
        end else begin
            state_r <= state_nxt;
            if (take) begin
                req_r <= REQ;
                ADDR <= REQ.addr;
                DQ_OUT <= REQ.wdata;
            end
            if (state_r == NPS_SETUP) begin
                cnt_r <= strobe_len;
            end else if (state_r == NPS_RELEASE) begin
                cnt_r <= CNT_W'(TURN_CYC);
            end else if (!cnt_done) begin
                cnt_r <= cnt_r - 1'b1;
            end
            CTL <= ctl_nxt;
            DQ_OE <= drive_nxt ? byte_oe : '0;
        end
    end

    // ------------------------------------------------------------
    // answer
    // ------------------------------------------------------------
    // sample after the synchroniser delay: data is held on the pins only through STROBE
    logic cap_r;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cap_r <= 1'b0;
            RDATA <= '0;
            RDATA_VALID <= 1'b0;
            REQ_READY <= 1'b0;
            FLASH_BUSY <= 1'b0;
        end else begin
            cap_r <= (state_r == NPS_STROBE) && (state_nxt == NPS_RELEASE) && !op_wr
                && (req_r.op == NPS_OP_FLASH_RD || req_r.op == NPS_OP_RAM_RD);
            RDATA_VALID <= cap_r;
            if (cap_r) begin
                RDATA <= pin_sync[DATA_W-1:0];
            end
            REQ_READY <= (state_nxt == NPS_IDLE) && !take;
            FLASH_BUSY <= wait_asserted;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // ram enable low-time count, so the wake check sees the whole exit hold
    logic [CNT_W-1:0] ce_low_r;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ce_low_r <= '0;
        end else begin
            ce_low_r <= CTL.ram_ce_n ? '0 : ce_low_r + 1'b1;
        end
    end

    one_die_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !(!CTL.flash_ce_n && !CTL.ram_ce_n)) else $error("both chip enables low");
    no_fight_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (DQ_OE != '0) |-> (CTL.flash_oe_n && CTL.ram_oe_n)) else $error("bus fight");
    clk_low_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !CTL.clk) else $error("clock line not low");
    flash_rd_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !CTL.flash_oe_n |-> (CTL.flash_reset_n && !CTL.flash_ce_n && CTL.flash_we_n
        && CTL.address_valid_latch_n && CTL.ram_ce_n)) else $error("flash read pins");
    ram_acc_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (!CTL.ram_oe_n || !CTL.ram_we_n) |-> (!CTL.ram_ce_n && CTL.flash_ce_n))
        else $error("ram access pins");
    byte_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (!CTL.ram_ce_n && CTL.upper_byte_enable_n) |-> (DQ_OE[15:8] == 8'h00))
        else $error("upper byte driven while disabled");
    low_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (!CTL.ram_ce_n && CTL.lower_byte_enable_n) |-> (DQ_OE[7:0] == 8'h00))
        else $error("lower byte driven while disabled");
    ce_handoff_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(CTL.flash_ce_n) |-> CTL.ram_ce_n) else $error("enables overlap");
    wake_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (req_r.op == NPS_OP_RAM_WAKE && $rose(CTL.ram_ce_n))
        |-> (ce_low_r >= CNT_W'(EXIT_HOLD)))
        else $error("wake hold too short");
endmodule : nps_host
`default_nettype wire

/* sim/nps_dev_model.sv */
/* nps_dev_model: behavioural flash plus pseudo static ram pair on the shared pins.
   Assumes pin controls from nps_host; the bench clock only paces sampling. */
`timescale 1ns/1ns
`default_nettype none
module nps_dev_model
    import nps_pkg::*;
#(
    parameter int EXIT_HOLD = 4
) (
    input wire logic clk,
    input wire nps_pkg::nps_ctl_t ctl,
    input wire logic [nps_pkg::ADDR_W-1:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic [15:0] dq_oe,
    input wire logic wait_high,
    input wire logic stall,
    input wire logic pd_bit,
    output logic [15:0] dq_in,
    output logic wait_out,
    output logic clash,
    output logic deep_power_down
);
    logic [15:0] fl [16];
    logic [15:0] rm [16];
    logic [15:0] pat = 16'h5a5a;
    logic [15:0] fdrv, rdrv, val, lat_d;
    logic [3:0] lat_a;
    logic fsel, rsel, prev_ce = 1'b1, prev_fw = 1'b1;
    int hold = 0;
    initial begin
        deep_power_down = 1'b0;
        for (int k = 0; k < 16; k++) begin
            fl[k] = 16'h1000 + 16'(k);
            rm[k] = 16'h2000 + 16'(k);
        end
    end
    // ----
    // pin decode; released lines show a moving pattern, not the last value
    // ----
    assign fsel = ctl.flash_reset_n && !ctl.flash_ce_n;
    assign rsel = !ctl.ram_ce_n && !deep_power_down;
    assign fdrv = {16{fsel && !ctl.flash_oe_n}};
    assign rdrv = {{8{rsel && !ctl.ram_oe_n && !ctl.upper_byte_enable_n}},
        {8{rsel && !ctl.ram_oe_n && !ctl.lower_byte_enable_n}}};
    assign val = (fdrv & fl[addr[3:0]]) | (rdrv & rm[addr[3:0]]);
    assign dq_in = (dq_oe & dq_out) | (~dq_oe & val) | (~dq_oe & ~(fdrv | rdrv) & pat);
    assign clash = (|(dq_oe & (fdrv | rdrv))) || (|fdrv && |rdrv);
    assign wait_out = fsel ? ((stall && !ctl.flash_oe_n) == wait_high) : pat[0];
    always @(posedge clk) begin
        pat <= {pat[14:0], ~pat[15]};
        prev_ce <= ctl.ram_ce_n;
        prev_fw <= !fsel || ctl.flash_we_n;
        lat_a <= addr[3:0];
        lat_d <= dq_in;
        if (!prev_fw && (!fsel || ctl.flash_we_n)) begin
            fl[lat_a] <= lat_d;
        end
        if (rsel && !ctl.ram_we_n && !ctl.upper_byte_enable_n) begin
            rm[addr[3:0]][15:8] <= dq_in[15:8];
        end
        if (rsel && !ctl.ram_we_n && !ctl.lower_byte_enable_n) begin
            rm[addr[3:0]][7:0] <= dq_in[7:0];
        end
        if (!prev_ce && ctl.ram_ce_n && !pd_bit) begin
            deep_power_down <= 1'b1;
        end
        hold <= (deep_power_down && !ctl.ram_ce_n) ? hold + 1 : 0;
        if (deep_power_down && !ctl.ram_ce_n && hold + 1 >= EXIT_HOLD) begin
            deep_power_down <= 1'b0;
        end
    end
endmodule : nps_dev_model
`default_nettype wire

/* sim/tb_nps_host.sv */
/* tb_nps_host: self-checking bench for nps_host against nps_dev_model.
   Assumes the hand-over timing; exit hold shrunk to 4 cycles to keep runs short. */
`timescale 1ns/1ns
`default_nettype none
module tb_nps_host;
    import nps_pkg::*;
    localparam int HOLD = 4;
    logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0;
    logic wah = 1'b0, stall = 1'b0, pd_bit = 1'b1;
    nps_req_t req = '0;
    logic req_ready, rdata_valid, flash_busy, wait_in, clash, deep_power_down;
    logic [15:0] rdata, dq_out, dq_oe, dq_in;
    logic [ADDR_W-1:0] addr;
    nps_ctl_t ctl;
    logic [15:0] fl_ref [16];
    logic [15:0] rm_ref [16];
    int num_errors = 0, n_checks = 0, cycles = 0, seed = 32'h9e58;

    nps_host #(.EXIT_HOLD(HOLD)) DUT (.SYS_CLK(clk), .RST_N(rst_n), .REQ(req),
        .REQ_VALID(req_valid), .REQ_READY(req_ready), .WAIT_ACTIVE_HIGH(wah),
        .RDATA(rdata), .RDATA_VALID(rdata_valid), .FLASH_BUSY(flash_busy), .ADDR(addr),
        .DQ_OUT(dq_out), .DQ_OE(dq_oe), .DQ_IN(dq_in), .WAIT_IN(wait_in), .CTL(ctl));
    nps_dev_model #(.EXIT_HOLD(HOLD)) dev (.clk(clk), .ctl(ctl), .addr(addr),
        .dq_out(dq_out), .dq_oe(dq_oe), .wait_high(wah), .stall(stall),
        .pd_bit(pd_bit), .dq_in(dq_in), .wait_out(wait_in), .clash(clash), .deep_power_down(deep_power_down));

    initial forever #25 clk = ~clk;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // ----
    // one request, waits for read data and for the return to idle
    // ----
    task automatic run(input nps_op_t op, input logic [3:0] a, input logic [15:0] d,
        input logic u, input logic l);
        logic [15:0] m;
        m = {{8{u}}, {8{l}}};
        @(posedge clk);
        #2 req = '{op: op, addr: ADDR_W'(a), wdata: d, upper_en: u, lower_en: l};
        req_valid = 1'b1;
        do @(negedge clk); while (req_ready !== 1'b1);
        @(posedge clk);
        #2 req_valid = 1'b0;
        if (op == NPS_OP_FLASH_RD || op == NPS_OP_RAM_RD) begin
            do @(negedge clk); while (rdata_valid !== 1'b1);
            if (op == NPS_OP_FLASH_RD) check(rdata, fl_ref[a]);
            else check(rdata & m, rm_ref[a] & m);
        end
        if (op == NPS_OP_RAM_WR) rm_ref[a] = {u ? d[15:8] : rm_ref[a][15:8],
            l ? d[7:0] : rm_ref[a][7:0]};
        if (op == NPS_OP_FLASH_WR) fl_ref[a] = d;
        do @(negedge clk); while (req_ready !== 1'b1);
    endtask : run

    // pin watch every cycle; hang guard far above the expected run length
    always @(negedge clk) begin
        if (rst_n) begin
            check({15'h0, ctl.clk}, 16'h0);
            check({15'h0, ctl.flash_ce_n | ctl.ram_ce_n}, 16'h1);
            check({15'h0, clash}, 16'h0);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            stop_test();
        end
    end

    initial begin
        logic [31:0] r;
        for (int k = 0; k < 16; k++) begin
            fl_ref[k] = 16'h1000 + 16'(k);
            rm_ref[k] = 16'h2000 + 16'(k);
        end
        repeat (5) @(posedge clk);
        check({5'h0, ctl}, {5'h0, CTL_IDLE});
        check(dq_oe, 16'h0);
        #2 rst_n = 1'b1;
        // every byte-enable pair, each read back as a whole word
        for (int k = 0; k < 4; k++) begin
            run(NPS_OP_RAM_WR, 4'(k), 16'hc3a5 ^ 16'(k), k[1], k[0]);
            run(NPS_OP_RAM_RD, 4'(k), 16'h0, 1'b1, 1'b1);
        end
        run(NPS_OP_FLASH_WR, 4'h5, 16'hbeef, 1'b1, 1'b1);
        run(NPS_OP_FLASH_RD, 4'h5, 16'h0, 1'b1, 1'b1);
        // stretched flash read under both wait polarities
        for (int w = 0; w < 2; w++) begin
            @(posedge clk);
            #2 wah = w[0];
            stall = 1'b1;
            fork
                run(NPS_OP_FLASH_RD, 4'(w), 16'h0, 1'b1, 1'b1);
                begin
                    repeat (12) @(negedge clk);
                    check({15'h0, flash_busy}, 16'h1);
                    stall = 1'b0;
                end
            join
        end
        repeat (40) begin
            r = $random(seed);
            run(nps_op_t'({1'b0, r[1:0]}), r[5:2], r[21:6], r[22], r[23]);
        end
        run(NPS_OP_FLASH_RST, 4'h0, 16'h0, 1'b1, 1'b1);
        run(NPS_OP_FLASH_RD, 4'h3, 16'h0, 1'b1, 1'b1);
        pd_bit = 1'b0;
        run(NPS_OP_RAM_WR, 4'h7, 16'h1234, 1'b1, 1'b1);
        check({15'h0, deep_power_down}, 16'h1);
        pd_bit = 1'b1;
        run(NPS_OP_RAM_WAKE, 4'h0, 16'h0, 1'b1, 1'b1);
        check({15'h0, deep_power_down}, 16'h0);
        run(NPS_OP_RAM_RD, 4'h7, 16'h0, 1'b1, 1'b1);
        stop_test();
    end
endmodule : tb_nps_host
`default_nettype wire
